// File: rtl/sram_host_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module sram_host_ctrl (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic [sram_host_pkg::ADDR_W-1:0] req_addr,
  input wire logic [sram_host_pkg::DATA_W-1:0] req_wdata,
  output logic req_ready,
  output logic rsp_valid,
  output logic [sram_host_pkg::DATA_W-1:0] rsp_rdata,
  input wire logic retain_req,
  output logic retain_ack,
  output logic [sram_host_pkg::ADDR_W-1:0] mem_addr,
  output logic select_low_active_n,
  output logic select_high_active,
  output logic write_strobe_n,
  output logic output_enable_n,
  output logic [sram_host_pkg::DATA_W-1:0] mem_data_out,
  output logic mem_data_oe,
  input wire logic [sram_host_pkg::DATA_W-1:0] mem_data_in
);
  import sram_host_pkg::*;

  // ------------------------------------------------------------
  // state and timer
  // ------------------------------------------------------------
  host_state_t state_reg;
  host_state_t state_next;
  logic tmr_load;
  logic [CNT_W-1:0] tmr_val;
  logic tmr_done;

  sram_cycle_timer u_timer (
    .core_clk(core_clk),
    .resetn(resetn),
    .load(tmr_load),
    .load_val(tmr_val),
    .done(tmr_done)
  );

  logic [ADDR_W-1:0] addr_reg;
  logic [ADDR_W-1:0] addr_next;
  logic [DATA_W-1:0] wdata_reg;
  logic [DATA_W-1:0] wdata_next;
  logic [DATA_W-1:0] rdata_reg;
  logic [DATA_W-1:0] rdata_next;
  logic sel_reg;
  logic sel_next;
  logic strobe_n_reg;
  logic strobe_n_next;
  logic oe_n_reg;
  logic oe_n_next;
  logic drive_reg;
  logic drive_next;
  logic ready_reg;
  logic ready_next;
  logic rsp_reg;
  logic rsp_next;
  logic ack_reg;
  logic ack_next;

  // ------------------------------------------------------------
  // sequencing
  // ------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    tmr_load = 1'b0;
    tmr_val = CNT_ZERO;
    addr_next = addr_reg;
    wdata_next = wdata_reg;
    rdata_next = rdata_reg;
    rsp_next = 1'b0;
    case (state_reg)
      ST_IDLE: begin
        // retention wins over a pending access so entry is not delayed
        if (retain_req) begin
          state_next = ST_RETAIN;
        end else if (req_valid) begin
          addr_next = req_addr;
          wdata_next = req_wdata;
          tmr_load = 1'b1;
          if (req_write) begin
            state_next = ST_WR_SETUP;
            tmr_val = CNT_ZERO;
          end else begin
            state_next = ST_RD_ACCESS;
            tmr_val = ACCESS_LOAD;
          end
        end
      end
      ST_RD_ACCESS: begin
        if (tmr_done) begin
          rdata_next = mem_data_in;
          rsp_next = 1'b1;
          state_next = ST_RD_RELEASE;
          tmr_load = 1'b1;
          tmr_val = RELEASE_LOAD;
        end
      end
      ST_RD_RELEASE: begin
        // the memory may still drive; no write may start until it lets go
        if (tmr_done) begin
          state_next = ST_IDLE;
        end
      end
      ST_WR_SETUP: begin
        state_next = ST_WR_PULSE;
        tmr_load = 1'b1;
        tmr_val = PULSE_LOAD;
      end
      ST_WR_PULSE: begin
        if (tmr_done) begin
          state_next = ST_WR_HOLD;
          tmr_load = 1'b1;
          tmr_val = HOLD_LOAD;
        end
      end
      ST_WR_HOLD: begin
        if (tmr_done) begin
          state_next = ST_IDLE;
        end
      end
      ST_RETAIN: begin
        if (!retain_req) begin
          state_next = ST_RECOVER;
          tmr_load = 1'b1;
          tmr_val = RECOVER_LOAD;
        end
      end
      ST_RECOVER: begin
        if (tmr_done) begin
          state_next = ST_IDLE;
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  // ------------------------------------------------------------
  // pin levels follow the next state so they leave flip-flops
  // ------------------------------------------------------------
  always_comb begin
    sel_next = 1'b0;
    strobe_n_next = 1'b1;
    oe_n_next = 1'b1;
    drive_next = 1'b0;
    ready_next = 1'b0;
    ack_next = 1'b0;
    case (state_next)
      ST_IDLE: begin
        ready_next = !retain_req;
      end
      ST_RD_ACCESS: begin
        sel_next = 1'b1;
        oe_n_next = 1'b0;
      end
      ST_WR_SETUP, ST_WR_HOLD: begin
        sel_next = 1'b1;
        drive_next = 1'b1;
      end
      ST_WR_PULSE: begin
        // enable stays high here, so the longer pulse is never needed
        sel_next = 1'b1;
        strobe_n_next = 1'b0;
        drive_next = 1'b1;
      end
      ST_RETAIN: begin
        ack_next = 1'b1;
      end
      default: begin
        sel_next = 1'b0;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      state_reg <= ST_IDLE;
      addr_reg <= '0;
      wdata_reg <= '0;
      rdata_reg <= '0;
      sel_reg <= 1'b0;
      strobe_n_reg <= 1'b1;
      oe_n_reg <= 1'b1;
      drive_reg <= 1'b0;
      ready_reg <= 1'b0;
      rsp_reg <= 1'b0;
      ack_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      addr_reg <= addr_next;
      wdata_reg <= wdata_next;
      rdata_reg <= rdata_next;
      sel_reg <= sel_next;
      strobe_n_reg <= strobe_n_next;
      oe_n_reg <= oe_n_next;
      drive_reg <= drive_next;
      ready_reg <= ready_next;
      rsp_reg <= rsp_next;
      ack_reg <= ack_next;
    end
  end

  assign req_ready = ready_reg;
  assign rsp_valid = rsp_reg;
  assign rsp_rdata = rdata_reg;
  assign retain_ack = ack_reg;
  assign mem_addr = addr_reg;
  assign select_low_active_n = !sel_reg;
  assign select_high_active = sel_reg;
  assign write_strobe_n = strobe_n_reg;
  assign output_enable_n = oe_n_reg;
  assign mem_data_out = wdata_reg;
  assign mem_data_oe = drive_reg;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  a_write_overlap: assert property (@(posedge core_clk) disable iff (!resetn)
    !write_strobe_n |-> select_high_active && !select_low_active_n)
    else $error("strobe low without both selects");

  a_pulse_width: assert property (@(posedge core_clk) disable iff (!resetn)
    $fell(write_strobe_n) |-> !write_strobe_n [*7] ##1 write_strobe_n)
    else $error("write strobe pulse not seven cycles");

  a_data_hold: assert property (@(posedge core_clk) disable iff (!resetn)
    $rose(write_strobe_n) |-> mem_data_oe && $stable(mem_data_out)
      && $past(mem_data_oe, 5))
    else $error("write data not held around write end");

  a_addr_stable: assert property (@(posedge core_clk) disable iff (!resetn)
    !write_strobe_n |-> $stable(mem_addr) ##1 $stable(mem_addr))
    else $error("address moved during write");

  a_select_lead: assert property (@(posedge core_clk) disable iff (!resetn)
    $rose(write_strobe_n) |-> $past(select_high_active, 8))
    else $error("selects not active long enough before write end");

  a_bus_no_fight: assert property (@(posedge core_clk) disable iff (!resetn)
    mem_data_oe |-> output_enable_n && $past(output_enable_n, 4))
    else $error("host drives while memory may drive");

  a_strobe_read: assert property (@(posedge core_clk) disable iff (!resetn)
    !output_enable_n |-> write_strobe_n)
    else $error("strobe low during read");

  a_read_span: assert property (@(posedge core_clk) disable iff (!resetn)
    $fell(output_enable_n) |-> !output_enable_n [*8] ##1 !output_enable_n
      ##1 rsp_valid)
    else $error("read access shorter than nine cycles");

  a_retain_desel: assert property (@(posedge core_clk) disable iff (!resetn)
    $fell(retain_ack) |-> !select_high_active [*8] ##1 !select_high_active)
    else $error("access resumed before recovery");

endmodule
`default_nettype wire

// File: rtl/sram_host_pkg.sv
package sram_host_pkg;

  // ------------------------------------------------------------
  // widths
  // ------------------------------------------------------------
  localparam int ADDR_W = 17;
  localparam int DATA_W = 8;
  localparam int CNT_W = 8;

  // ------------------------------------------------------------
  // memory timing in ns
  // ------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 5;
  localparam int READ_CYCLE_TIME_NS = 45;
  localparam int ADDRESS_ACCESS_TIME_NS = 45;
  localparam int SELECT_ACCESS_TIME_NS = 45;
  localparam int OUTPUT_ENABLE_RELEASE_DELAY_NS = 18;
  localparam int SELECT_RELEASE_DELAY_NS = 18;
  localparam int WRITE_CYCLE_TIME_NS = 45;
  localparam int SELECT_TO_WRITE_END_NS = 35;
  localparam int ADDRESS_TO_WRITE_END_NS = 35;
  localparam int WRITE_PULSE_WIDTH_NS = 35;
  localparam int DATA_SETUP_TO_WRITE_END_NS = 25;
  localparam int RETENTION_RECOVERY_TIME_NS = 45;

  // ------------------------------------------------------------
  // cycle counts, least times rounded up
  // ------------------------------------------------------------
  function automatic int ceil_cyc(input int ns);
    int c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction

  function automatic int max2(input int a, input int b);
    return (a > b) ? a : b;
  endfunction

  localparam int ACCESS_CYC = max2(ceil_cyc(READ_CYCLE_TIME_NS),
    max2(ceil_cyc(ADDRESS_ACCESS_TIME_NS), ceil_cyc(SELECT_ACCESS_TIME_NS)));
  localparam int RELEASE_CYC = max2(
    ceil_cyc(OUTPUT_ENABLE_RELEASE_DELAY_NS),
    ceil_cyc(SELECT_RELEASE_DELAY_NS));
  localparam int PULSE_CYC = max2(ceil_cyc(WRITE_PULSE_WIDTH_NS),
    max2(ceil_cyc(DATA_SETUP_TO_WRITE_END_NS),
    max2(ceil_cyc(SELECT_TO_WRITE_END_NS),
    ceil_cyc(ADDRESS_TO_WRITE_END_NS))));
  localparam int SETUP_CYC = 1;
  localparam int HOLD_CYC = max2(1,
    ceil_cyc(WRITE_CYCLE_TIME_NS) - PULSE_CYC - SETUP_CYC);
  localparam int RECOVER_CYC = ceil_cyc(RETENTION_RECOVERY_TIME_NS);

  localparam logic [CNT_W-1:0] ACCESS_LOAD = CNT_W'(ACCESS_CYC - 1);
  localparam logic [CNT_W-1:0] RELEASE_LOAD = CNT_W'(RELEASE_CYC - 1);
  localparam logic [CNT_W-1:0] PULSE_LOAD = CNT_W'(PULSE_CYC - 1);
  localparam logic [CNT_W-1:0] HOLD_LOAD = CNT_W'(HOLD_CYC - 1);
  localparam logic [CNT_W-1:0] RECOVER_LOAD = CNT_W'(RECOVER_CYC - 1);
  localparam logic [CNT_W-1:0] CNT_ZERO = 8'h00;

  // ------------------------------------------------------------
  // controller states
  // ------------------------------------------------------------
  typedef enum logic [7:0] {
    ST_IDLE = 8'h01,
    ST_RD_ACCESS = 8'h02,
    ST_RD_RELEASE = 8'h04,
    ST_WR_SETUP = 8'h08,
    ST_WR_PULSE = 8'h10,
    ST_WR_HOLD = 8'h20,
    ST_RETAIN = 8'h40,
    ST_RECOVER = 8'h80
  } host_state_t;

endpackage

// File: rtl/sram_cycle_timer.sv
`timescale 1ns/1ps
`default_nettype none
module sram_cycle_timer
  import sram_host_pkg::*;
(
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic load,
  input wire logic [sram_host_pkg::CNT_W-1:0] load_val,
  output logic done
);

  logic [CNT_W-1:0] cnt_reg;
  logic [CNT_W-1:0] cnt_next;

  always_comb begin
    cnt_next = cnt_reg;
    if (load) begin
      cnt_next = load_val;
    end else if (cnt_reg != CNT_ZERO) begin
      cnt_next = cnt_reg - 8'h01;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      cnt_reg <= 8'h00;
    end else begin
      cnt_reg <= cnt_next;
    end
  end

  assign done = (cnt_reg == CNT_ZERO);

endmodule
`default_nettype wire

// File: tb/sram_dev_model.sv
`timescale 1ns/1ps
`default_nettype none
module sram_dev_model #(
  parameter int ACC_NS = 45
) (
  input wire logic [sram_host_pkg::ADDR_W-1:0] addr,
  input wire logic select_low_active_n,
  input wire logic select_high_active,
  input wire logic write_strobe_n,
  input wire logic output_enable_n,
  input wire logic [sram_host_pkg::DATA_W-1:0] host_d,
  input wire logic host_oe,
  output logic [sram_host_pkg::DATA_W-1:0] pin_level,
  output int viol
);
  import sram_host_pkg::*;
  // ------------------------------------------------------------
  // array and edge times
  // ------------------------------------------------------------
  logic [DATA_W-1:0] mem [logic [ADDR_W-1:0]];
  logic [DATA_W-1:0] last_q, rd;
  logic act, wr, drv, ok, last_drv;
  logic in_wr = 1'b0;
  int viol_wr = 0, viol_bus = 0;
  realtime t_a = 0, t_s = 0, t_o = 0, t_d = 0, t_we = 0;
  realtime t_oh = 0, t_ds = 0, t_wf = 0;
  assign viol = viol_wr + viol_bus;
  assign act = !select_low_active_n && select_high_active;
  assign wr = act && !write_strobe_n;
  always @(addr) t_a = $realtime;
  always @(posedge act) t_s = $realtime;
  always @(negedge output_enable_n) t_o = $realtime;
  always @(posedge write_strobe_n) t_we = $realtime;
  always @(posedge output_enable_n) t_oh = $realtime;
  always @(negedge act) t_ds = $realtime;
  always @(negedge write_strobe_n) t_wf = $realtime;
  always @(host_d or host_oe) t_d = $realtime;
  // the write lands when the overlap closes, whichever pin ends it
  always @(wr) begin
    if (wr === 1'b1) in_wr = 1'b1;
    else if (in_wr) begin
      in_wr = 1'b0;
      if ($realtime - t_d < 25 || $realtime - t_a < 35) viol_wr++;
      if ($realtime - t_s < 35) viol_wr++;
      mem[addr] = host_d;
    end
  end
  // ------------------------------------------------------------
  // pins, sampled every ns; no pull, so a free bus keeps toggling
  // ------------------------------------------------------------
  initial begin
    last_q = 8'h00;
    last_drv = 1'b0;
    forever begin
      #1;
      rd = mem.exists(addr) ? mem[addr] : addr[7:0] ^ 8'h5a;
      drv = act && write_strobe_n && !output_enable_n;
      drv = drv && $realtime - t_o >= 5 && $realtime - t_s >= 10;
      drv = drv && $realtime - t_we >= 10;
      // a memory that was driving may keep on for up to 18 ns after release
      drv = drv || (last_drv && ($realtime - t_oh < 18 ||
        $realtime - t_ds < 18 ||
        $realtime - t_wf < 18));
      ok = $realtime - t_a >= ACC_NS && $realtime - t_s >= ACC_NS;
      ok = ok && $realtime - t_o >= 22;
      if (host_oe) begin
        if (drv) viol_bus++;
        pin_level = host_d;
      end else if (drv && ok) pin_level = rd;
      else if (drv && $realtime - t_a < 10) pin_level = last_q;
      else pin_level = ~last_q;
      last_q = pin_level;
      last_drv = drv;
    end
  end
endmodule
`default_nettype wire

// File: tb/async_sram_cycle_timing_tb.sv
`timescale 1ns/1ps
`default_nettype none
module async_sram_cycle_timing_tb;
  import sram_host_pkg::*;
  logic core_clk, resetn, req_valid, req_write, retain_req;
  logic req_ready, rsp_valid, retain_ack, mem_data_oe;
  logic select_low_active_n, select_high_active;
  logic write_strobe_n, output_enable_n;
  logic [ADDR_W-1:0] req_addr, mem_addr, a;
  logic [DATA_W-1:0] req_wdata, rsp_rdata, mem_data_out, mem_data_in, d;
  logic [DATA_W-1:0] ref_mem [logic [ADDR_W-1:0]];
  int err_total, num_checks, mdl_viol, seed, n, wc;

  sram_host_ctrl dut (.core_clk, .resetn, .req_valid, .req_write,
    .req_addr, .req_wdata, .req_ready, .rsp_valid, .rsp_rdata,
    .retain_req, .retain_ack, .mem_addr, .select_low_active_n,
    .select_high_active, .write_strobe_n, .output_enable_n,
    .mem_data_out, .mem_data_oe, .mem_data_in);
  // one ns short of the access limit: the host samples right at it
  sram_dev_model #(.ACC_NS(44)) mdl (.addr(mem_addr), .select_low_active_n,
    .select_high_active, .write_strobe_n, .output_enable_n,
    .host_d(mem_data_out), .host_oe(mem_data_oe),
    .pin_level(mem_data_in), .viol(mdl_viol));

  // ------------------------------------------------------------
  // compare and closing tasks
  // ------------------------------------------------------------
  task automatic check_data(input logic [DATA_W-1:0] got, exp);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic check_cyc(input int got, exp);
    num_checks++;
    if (got != exp) begin
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // sel: 0 read answer, 1 ready, 2 retention acknowledge
  task automatic wait_edges(input int sel);
    logic hit;
    wc = 0;
    do begin
      @(posedge core_clk);
      #1;
      wc++;
      hit = (sel == 2) ? retain_ack : (sel == 1) ? req_ready : rsp_valid;
    end while (hit !== 1'b1 && wc < 40);
  endtask
  task automatic access(input logic w, input logic [ADDR_W-1:0] ad,
      input logic [DATA_W-1:0] wd);
    logic [DATA_W-1:0] e;
    int span;
    span = w ? WRITE_CYCLE_TIME_NS : READ_CYCLE_TIME_NS;
    wait_edges(1);
    @(posedge core_clk);
    req_valid <= 1'b1;
    req_write <= w;
    req_addr <= ad;
    req_wdata <= wd;
    @(posedge core_clk);
    req_valid <= 1'b0;
    wait_edges(w);
    check_cyc(wc, span / CLK_PERIOD_NS);
    if (w) ref_mem[ad] = wd;
    else begin
      e = ref_mem.exists(ad) ? ref_mem[ad] : ad[7:0] ^ 8'h5a;
      check_data(rsp_rdata, e);
    end
  endtask

  // ------------------------------------------------------------
  // clock, watchdog, sequence
  // ------------------------------------------------------------
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end
  initial begin
    #20000;
    err_total++;
    report_and_stop();
  end
  initial begin
    seed = 32'h2e238e42;
    err_total = 0;
    num_checks = 0;
    resetn = 1'b0;
    req_valid = 1'b0;
    req_write = 1'b0;
    req_addr = '0;
    req_wdata = '0;
    retain_req = 1'b0;
    repeat (16) @(posedge core_clk);
    resetn <= 1'b1;
    repeat (60) begin
      a = ADDR_W'($random(seed));
      a = {a[16:15], 12'h000, a[2:0]};
      d = DATA_W'($random(seed));
      n = $random(seed);
      access(n[0], a, d);
    end
    @(posedge core_clk);
    retain_req <= 1'b1;
    // the last access may still be releasing the bus, so wait for the ack
    wait_edges(2);
    d = {5'h00, retain_ack, select_low_active_n, select_high_active};
    check_data(d, 8'h06);
    check_data({7'h00, req_ready}, 8'h00);
    @(posedge core_clk);
    retain_req <= 1'b0;
    wait_edges(1);
    check_cyc(wc, 10);
    access(1'b0, a, d);
    check_cyc(mdl_viol, 0);
    report_and_stop();
  end
endmodule
`default_nettype wire
